// [tb_top.sv]
// Self-checking bench for the serial readout framer and its error monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tdc_readout_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rx_word;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pkt_ready, ser_data, ser_strobe, rx_valid, rx_perr;
  logic [1:0] bresp, rresp, spd = 2'b00;
  pkt_s pkt_in = '0;
  logic pkt_valid = 1'b0, tval = 1'b0, tpar = 1'b0, ds_mode = 1'b0;
  logic [4:0] herr = 5'h00;
  logic [3:0] terr = 4'h0, tins = 4'h0, id = 4'h0;
  logic [15:0] rx_span;
  logic [31:0] exp_q[$];
  logic [3:0] ptypes [6] = '{PT_HEADER, PT_TRAILER, PT_MASK, PT_SINGLE, PT_COMBINED, PT_DEBUG};
  logic [3:0] rsv [9] = '{4'h0, 4'h1, 4'h5, 4'h8, 4'h9, 4'hB, 4'hD, 4'hE, 4'hF};
  logic [15:0] spans [4] = '{16'h0042, 16'h0042, 16'h00C6, 16'h018C};
  int errors = 0, compares = 0, seed = 58125, i;

  initial forever #4 clk_sys = ~clk_sys;

  tdc_serial_readout_errmon u_tdc_serial_readout_errmon (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pkt_in(pkt_in), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .hard_err_in(herr), .temp_err_in(terr), .test_instr(tins), .test_instr_par(tpar),
    .test_instr_valid(tval), .ser_data(ser_data), .ser_strobe(ser_strobe));

  tdc_rx_model u_tdc_rx_model (.clk_sys(clk_sys), .rst_n(rst_n), .ser_data(ser_data),
    .ser_strobe(ser_strobe), .ds_mode(ds_mode), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_perr(rx_perr), .rx_span(rx_span));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Ready stands with the request, so each answer is taken at the first edge where it shows.
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                     input logic [31:0] ed, input logic [31:0] msk);
    int n;
    logic done;
    done = 1'b0;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    arvalid <= !wr;
    bready <= wr;
    rready <= !wr;
    for (n = 0; n < 100 && !done; n++)
    begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      done = (bvalid && bready) || (rvalid && rready);
    end
    check("bus done", {31'h0, done}, 32'h0000_0001);
    check("bus resp", {30'h0, wr ? bresp : rresp}, {30'h0, er});
    if (!wr) check("read data", rdata & msk, ed);
  endtask : axi

  // Holds valid up between words so back-to-back sends never lower and raise it at one edge.
  task automatic send(input logic [3:0] t, input logic [23:0] b, input logic ex);
    int n;
    n = 0;
    pkt_in <= '{ptype: t, body: b, par: ^{t, b}};
    pkt_valid <= 1'b1;
    if (ex) exp_q.push_back({t, id, b});
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (!pkt_ready && n < 2000);
  endtask : send

  task automatic drain();
    int n;
    pkt_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (n = 0; n < 3000 && (exp_q.size() > 0 || !pkt_ready); n++) @(posedge clk_sys);
    check("pending frames", exp_q.size(), 32'h0000_0000);
  endtask : drain

  always @(posedge clk_sys)
  begin
    if (rx_valid && exp_q.size() == 0) check("unexpected frame", rx_word, 32'h0000_0000);
    else if (rx_valid) check("frame word", rx_word, exp_q.pop_front());
    if (rx_valid) check("bit span", {16'h0, rx_span}, {16'h0, spans[spd]});
    if (rx_perr) check("frame parity", 32'h0000_0001, 32'h0000_0000);
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    axi(0, REG_CTRL, 0, RESP_OKAY, CTRL_RESET, 32'hFFFF_FFFF);
    axi(0, REG_ERR_ENABLE, 0, RESP_OKAY, 32'h0000_01FF, 32'hFFFF_FFFF);
    axi(0, REG_ERR_STATUS, 0, RESP_OKAY, 32'h0000_0000, 32'hFFFF_FFFF);
    axi(0, REG_TX_STATE, 0, RESP_OKAY, 32'h0000_0001, 32'h0000_FF0F);
    axi(0, 8'h10, 0, RESP_SLVERR, 32'h0000_0000, 32'hFFFF_FFFF);
    axi(1, 8'h14, 32'hFFFF_FFFF, RESP_SLVERR, 0, 0);
    for (i = 0; i < 8; i++)
    begin
      spd <= i[1:0];
      ds_mode <= i[2];
      id = 4'($random(seed));
      axi(1, REG_CTRL, {24'h00_0000, id, 1'b0, i[2], i[1:0]}, RESP_OKAY, 0, 0);
      repeat (2) send(ptypes[$unsigned($random(seed)) % 6], 24'($random(seed)), 1'b1);
      drain();
    end
    for (i = 0; i < 9; i++) send(rsv[i], 24'($random(seed)), 1'b0);
    send(PT_HEADER, 24'($random(seed)), 1'b1);
    drain();
    axi(0, REG_TX_STATE, 0, RESP_OKAY, 32'h0000_0901, 32'h0000_FF0F);
    spd <= 2'b00;
    ds_mode <= 1'b0;
    axi(1, REG_CTRL, {24'h00_0000, id, 4'h0}, RESP_OKAY, 0, 0);
    herr <= 5'h01;
    terr <= 4'h4;
    tins <= 4'h3;
    tpar <= 1'b1;
    tval <= 1'b1;
    @(posedge clk_sys);
    herr <= 5'h00;
    terr <= 4'h0;
    tval <= 1'b0;
    axi(0, REG_ERR_STATUS, 0, RESP_OKAY, 32'h0000_0101, 32'hFFFF_FFFF);
    exp_q.push_back({PT_ERROR, id, 11'h000, 13'h0901});
    send(PT_TRAILER, 24'($random(seed)), 1'b1);
    drain();
    axi(1, REG_ERR_STATUS, 32'h0000_01FF, RESP_OKAY, 0, 0);
    axi(0, REG_ERR_STATUS, 0, RESP_OKAY, 32'h0000_0000, 32'hFFFF_FFFF);
    send(PT_TRAILER, 24'($random(seed)), 1'b1);
    drain();
    print_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// [tdc_readout_pkg.sv]
// Shared constants, register map and carrier types of the serial readout formatter.
package tdc_readout_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ERR_ENABLE = 8'h04;
  localparam logic [7:0] REG_ERR_STATUS = 8'h08;
  localparam logic [7:0] REG_TX_STATE = 8'h0C;

  // Control word fields.
  localparam int CTRL_SPEED_LSB = 0;
  localparam int CTRL_STROBE_BIT = 2;
  localparam int CTRL_ID_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [8:0] ERR_ENABLE_RESET = 9'h1FF;

  // Hard error bit positions; temporal ones follow in the error word.
  localparam int HERR_N = 9;
  localparam int HERR_FIFO_PAR = 5;
  localparam int HERR_RO_STATE = 6;
  localparam int HERR_CTRL_PAR = 7;
  localparam int HERR_TEST_PAR = 8;
  localparam int HERR_EXT_N = 5;
  localparam int TERR_N = 4;
  localparam int EWORD_N = HERR_N + TERR_N;

  // Packet type codes in bits 31:28.
  localparam logic [3:0] PT_HEADER = 4'hA;
  localparam logic [3:0] PT_TRAILER = 4'hC;
  localparam logic [3:0] PT_MASK = 4'h2;
  localparam logic [3:0] PT_SINGLE = 4'h3;
  localparam logic [3:0] PT_COMBINED = 4'h4;
  localparam logic [3:0] PT_ERROR = 4'h6;
  localparam logic [3:0] PT_DEBUG = 4'h7;

  // Serial frame: start, 32 data, parity, two stops.
  localparam int DATA_BITS = 32;
  localparam int FRAME_BITS = DATA_BITS + 4;
  localparam logic START_LEVEL = 1'b1;
  localparam logic STOP_LEVEL = 1'b0;

  // Bit rates per speed code and the clock period.
  localparam int CLK_PERIOD_NS = 8;
  localparam int RATE0_MBPS = 80;
  localparam int RATE1_MBPS = 40;
  localparam int RATE2_MBPS = 20;
  localparam int RATE3_MBPS = 10;

  function automatic logic [3:0] half_cycles(input int mbps);
    int h;
    h = 1000 / (2 * mbps * CLK_PERIOD_NS);
    if (h < 1)
    begin
      h = 1;
    end
    return h[3:0];
  endfunction : half_cycles

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [3:0] ptype;
    logic [23:0] body;
    logic par;
  } pkt_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } ro_state_e;

endpackage : tdc_readout_pkg

// [tdc_readout_sva.sv]
// Concurrent checks on the ports of the serial readout framer.
`timescale 1ns/1ps
`default_nettype none
module tdc_readout_sva (
  input wire logic clk_sys, // Clock.
  input wire logic rst_n, // Reset, low.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic pkt_ready, // Packet ready.
  input wire logic ser_data // Serial data.
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_start_soon;
    ##[1:6] ser_data;
  endsequence
  property p_idle_low;
    pkt_ready |-> !ser_data;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("serial line not low while idle");
  property p_frame_start;
    $fell(pkt_ready) |-> s_start_soon;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("no start bit after take");
  property p_ready_back;
    !pkt_ready |-> ##[1:1000] pkt_ready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("packet input stuck busy");
  property p_wr_answer;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_b_hold;
    s_axi_bvalid |=> $past(s_axi_bready) ? !s_axi_bvalid : (s_axi_bvalid && $stable(s_axi_bresp));
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid |=> $past(s_axi_rready) ? !s_axi_rvalid : (s_axi_rvalid && $stable(s_axi_rdata));
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken during response");
  property p_r_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken during response");
endmodule : tdc_readout_sva
bind tdc_serial_readout_errmon tdc_readout_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pkt_ready(pkt_ready), .ser_data(ser_data));
`default_nettype wire

// [tdc_rx_model.sv]
// Behavioural downstream receiver that rebuilds words from the serial pair.
`timescale 1ns/1ps
`default_nettype none
module tdc_rx_model (
  input wire logic clk_sys, // Clock.
  input wire logic rst_n, // Reset, low.
  input wire logic ser_data, // Serial data.
  input wire logic ser_strobe, // Strobe.
  input wire logic ds_mode, // High for transition strobe format.
  output logic [31:0] rx_word, // Last received word, good or bad parity.
  output logic rx_valid, // Pulse per good word.
  output logic rx_perr, // Pulse per discarded word.
  output logic [15:0] rx_span // Cycles from start bit to parity bit.
);
  logic d_q, s_q, bit_ev;
  logic [5:0] cnt;
  logic [31:0] sh;
  logic [15:0] cyc, t0;
  // A bit lands on the rising strobe, or in transition format on any change of the pair.
  assign bit_ev = ds_mode ? ((ser_data ^ d_q) | (ser_strobe ^ s_q)) : (ser_strobe & ~s_q);
  always_ff @(posedge clk_sys)
  begin
    d_q <= ser_data;
    s_q <= ser_strobe;
    cyc <= cyc + 16'h0001;
    rx_valid <= 1'b0;
    rx_perr <= 1'b0;
    if (!rst_n)
    begin
      cnt <= 6'h00;
      cyc <= 16'h0000;
    end
    else if (bit_ev && cnt == 6'h00 && ser_data)
    begin
      cnt <= 6'h01;
      t0 <= cyc;
    end
    else if (bit_ev && cnt == 6'h21)
    begin
      cnt <= 6'h00;
      rx_word <= sh;
      rx_span <= cyc - t0;
      rx_valid <= ~^{sh, ser_data};
      rx_perr <= ^{sh, ser_data};
    end
    else if (bit_ev && cnt != 6'h00)
    begin
      sh <= {sh[30:0], ser_data};
      cnt <= cnt + 6'h01;
    end
  end
endmodule : tdc_rx_model
`default_nettype wire

// [tdc_serial_readout_errmon.sv]
// Serial readout framer with hard and temporal error monitoring behind an AXI4-Lite slave.
// Behaviour
// RL1 - Each packet leaves as start one, 32 data bits, parity, two stop bits.
// RL2 - Bit rate is chosen by a speed code from 80 down to 10 Mbit/s; codes 0 and 1 both give two-cycle bits, 62.5 Mbit/s.
// RL3 - Leading strobe mode drives the serializing clock; receiver samples on its rise.
// RL4 - Transition strobe toggles only when data repeats, one line changes per bit.
// RL5 - Packet bits 31:28 hold type, bits 27:24 the programmed chip identifier.
// RL6 - Only the seven defined type codes are sent; reserved codes are dropped.
// RL7 - Event order: header, measurements, mask flags, error word if any, trailer.
// RL8 - Measurement packets carry channel and time fields supplied by upstream logic.
// RL9 - Nine hard errors have enable bits 8:0 and latched flags at same positions.
// RL10 - Stored readout words carry parity, checked on every read.
// RL11 - State machines are one-hot; an illegal pattern is flagged as an error.
// RL12 - Test instruction carries parity; a corrupted load raises an error.
// RL13 - Control register holds parity; an upset bit raises the control parity error.
// RL14 - Hard errors show in the status register and in the event error word.
// RL15 - Bits 0 to 3: coarse count, channel select, hit buffer, trigger FIFO errors.
// RL16 - Bits 4 to 8: matching state, FIFO parity, readout state, control, test parity.
// RL17 - Temporal overflows appear only in the error word, never in status.
// RL18 - Error word bits 9 to 12: hit, trigger, readout overflows, corrupted hit.
// RL19 - Errors seen during an event produce a dedicated error word for it.
// RL20 - Parity is even over the data bits; the line rests low between frames.
// RL21 - Receiver waits for start one, takes 33 bits, drops frames with bad parity.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tdc_serial_readout_errmon #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Synchronous reset, low.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire tdc_readout_pkg::pkt_s pkt_in, // Packet from the readout store.
  input wire logic pkt_valid, // Packet valid.
  output logic pkt_ready, // Packet taken when high with valid.
  input wire logic [tdc_readout_pkg::HERR_EXT_N-1:0] hard_err_in, // Hard error pulses, bits 4:0.
  input wire logic [tdc_readout_pkg::TERR_N-1:0] temp_err_in, // Overflow pulses, error bits 12:9.
  input wire logic [3:0] test_instr, // Test port instruction.
  input wire logic test_instr_par, // Its parity bit.
  input wire logic test_instr_valid, // Instruction load strobe.
  output logic ser_data, // Serial data line.
  output logic ser_strobe // Strobe line.
);
  import tdc_readout_pkg::*;

  initial
  begin
    if (ADDR_W < 4 || ADDR_W > 32)
    begin
      $error("ADDR_W out of range");
    end
  end

  // Bus slave state.
  logic aw_ready_reg, w_ready_reg, b_valid_reg, ar_ready_reg, r_valid_reg;
  logic aw_held_reg, w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] b_resp_reg, r_resp_reg;
  logic [31:0] r_data_reg;
  logic wr_fire;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_mask;

  // Register contents.
  logic [31:0] ctrl_reg;
  logic ctrl_par_reg;
  logic [HERR_N-1:0] err_en_reg, err_stat_reg, herr_event;
  logic [EWORD_N-1:0] evt_err_reg;
  logic [7:0] drop_cnt_reg;

  // Readout path.
  ro_state_e state_reg;
  logic ready_reg, trl_pend_reg, tx_start_reg, state_err;
  logic [DATA_BITS-1:0] tx_word_reg, trl_word_reg;
  logic take, reserved, pkt_par_bad;
  logic [DATA_BITS-1:0] in_word, err_word;

  // Serializer.
  logic tx_busy_reg, phase_reg, ds_mode_reg, data_reg, strobe_reg;
  logic [FRAME_BITS-1:0] frame_reg;
  logic [5:0] bit_cnt_reg;
  logic [3:0] half_cnt_reg, half_len_reg, half_sel;
  logic tick;

  assign s_axi_awready = aw_ready_reg;
  assign s_axi_wready = w_ready_reg;
  assign s_axi_bvalid = b_valid_reg;
  assign s_axi_bresp = b_resp_reg;
  assign s_axi_arready = ar_ready_reg;
  assign s_axi_rvalid = r_valid_reg;
  assign s_axi_rdata = r_data_reg;
  assign s_axi_rresp = r_resp_reg;
  assign pkt_ready = ready_reg;
  assign ser_data = data_reg;
  assign ser_strobe = strobe_reg;

  assign wr_fire = aw_held_reg && w_held_reg && !b_valid_reg;
  assign wr_addr = 8'(aw_addr_reg);
  assign rd_addr = 8'(s_axi_araddr);
  assign wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // Write channel: address and data are taken in either order, the response follows both.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      aw_ready_reg <= 1'b1;
      w_ready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      b_valid_reg <= 1'b0;
      b_resp_reg <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && aw_ready_reg)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        aw_ready_reg <= 1'b0;
      end
      if (s_axi_wvalid && w_ready_reg)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        w_ready_reg <= 1'b0;
      end
      if (wr_fire)
      begin
        b_valid_reg <= 1'b1;
        b_resp_reg <= (wr_addr == REG_CTRL || wr_addr == REG_ERR_ENABLE ||
                       wr_addr == REG_ERR_STATUS || wr_addr == REG_TX_STATE) ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_valid_reg && s_axi_bready)
      begin
        b_valid_reg <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        aw_ready_reg <= 1'b1;
        w_ready_reg <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ar_ready_reg <= 1'b1;
      r_valid_reg <= 1'b0;
      r_data_reg <= '0;
      r_resp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && ar_ready_reg)
    begin
      ar_ready_reg <= 1'b0;
      r_valid_reg <= 1'b1;
      r_resp_reg <= RESP_OKAY;
      unique case (rd_addr)
        REG_CTRL: r_data_reg <= ctrl_reg;
        REG_ERR_ENABLE: r_data_reg <= 32'(err_en_reg);
        REG_ERR_STATUS: r_data_reg <= 32'(err_stat_reg); // RL14 RL17
        REG_TX_STATE: r_data_reg <= {16'h0000, drop_cnt_reg, 4'h0, trl_pend_reg, tx_busy_reg, state_reg};
        default:
        begin
          r_data_reg <= '0;
          r_resp_reg <= RESP_SLVERR;
        end
      endcase
    end
    else if (r_valid_reg && s_axi_rready)
    begin
      r_valid_reg <= 1'b0;
      ar_ready_reg <= 1'b1;
    end
  end

  // The parity bit is recomputed only on a bus write, so a later upset shows as a mismatch.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= CTRL_RESET;
      ctrl_par_reg <= ^CTRL_RESET; // RL13
    end
    else if (wr_fire && wr_addr == REG_CTRL)
    begin
      ctrl_reg <= (ctrl_reg & ~wr_mask) | (w_data_reg & wr_mask);
      ctrl_par_reg <= ^((ctrl_reg & ~wr_mask) | (w_data_reg & wr_mask)); // RL13
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      err_en_reg <= ERR_ENABLE_RESET;
    end
    else if (wr_fire && wr_addr == REG_ERR_ENABLE)
    begin
      err_en_reg <= (err_en_reg & ~wr_mask[HERR_N-1:0]) | (w_data_reg[HERR_N-1:0] & wr_mask[HERR_N-1:0]); // RL9
    end
  end

  // Raw hard error events before enabling.
  always_comb
  begin
    herr_event = '0;
    herr_event[HERR_EXT_N-1:0] = hard_err_in; // RL15 RL16
    herr_event[HERR_FIFO_PAR] = pkt_par_bad; // RL10
    herr_event[HERR_RO_STATE] = state_err; // RL11
    herr_event[HERR_CTRL_PAR] = (^ctrl_reg) != ctrl_par_reg; // RL13
    herr_event[HERR_TEST_PAR] = test_instr_valid && ((^test_instr) != test_instr_par); // RL12
  end

  // Sticky status, cleared by writing one; a new event in the clearing cycle wins.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      err_stat_reg <= '0;
    end
    else
    begin
      err_stat_reg <= (err_stat_reg & ~((wr_fire && wr_addr == REG_ERR_STATUS) ?
                       (w_data_reg[HERR_N-1:0] & wr_mask[HERR_N-1:0]) : '0)) |
                      (herr_event & err_en_reg); // RL9
    end
  end

  // Per-event error collection; overflows live only here and never reach status.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      evt_err_reg <= '0;
    end
    else
    begin
      evt_err_reg <= ((take && !reserved && in_word[31:28] == PT_TRAILER) ? '0 : evt_err_reg) |
                     {temp_err_in, herr_event & err_en_reg}; // RL17 RL18 RL19
    end
  end

  assign in_word = {pkt_in.ptype, ctrl_reg[CTRL_ID_LSB +: 4], pkt_in.body}; // RL5 RL8
  assign take = pkt_valid && ready_reg;
  assign pkt_par_bad = take && ((^{pkt_in.ptype, pkt_in.body}) != pkt_in.par); // RL10
  assign err_word = {PT_ERROR, ctrl_reg[CTRL_ID_LSB +: 4], 11'h000, evt_err_reg}; // RL14 RL18

  always_comb
  begin
    unique case (pkt_in.ptype)
      PT_HEADER, PT_TRAILER, PT_MASK, PT_SINGLE, PT_COMBINED, PT_ERROR, PT_DEBUG: reserved = 1'b0;
      default: reserved = 1'b1; // RL6
    endcase
  end

  // Readout sequencer: an error word is slotted in ahead of the trailer when errors occurred.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b1;
      trl_pend_reg <= 1'b0;
      tx_start_reg <= 1'b0;
      tx_word_reg <= '0;
      trl_word_reg <= '0;
      state_err <= 1'b0;
      drop_cnt_reg <= '0;
    end
    else
    begin
      tx_start_reg <= 1'b0;
      state_err <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          if (take && reserved)
          begin
            drop_cnt_reg <= drop_cnt_reg + 8'h01; // RL6
          end
          else if (take)
          begin
            ready_reg <= 1'b0;
            tx_start_reg <= 1'b1;
            state_reg <= ST_SEND;
            if (in_word[31:28] == PT_TRAILER && evt_err_reg != '0)
            begin
              tx_word_reg <= err_word; // RL7 RL19
              trl_word_reg <= in_word;
              trl_pend_reg <= 1'b1;
            end
            else
            begin
              tx_word_reg <= in_word; // RL7
            end
          end
        end
        ST_SEND:
        begin
          if (!tx_busy_reg && !tx_start_reg && trl_pend_reg)
          begin
            tx_word_reg <= trl_word_reg; // RL7
            trl_pend_reg <= 1'b0;
            tx_start_reg <= 1'b1;
          end
          else if (!tx_busy_reg && !tx_start_reg)
          begin
            state_reg <= ST_IDLE;
            ready_reg <= 1'b1;
          end
        end
        default:
        begin
          state_err <= 1'b1; // RL11
          state_reg <= ST_IDLE;
          ready_reg <= 1'b1;
          trl_pend_reg <= 1'b0;
        end
      endcase
    end
  end

  always_comb
  begin
    unique case (ctrl_reg[CTRL_SPEED_LSB +: 2])
      2'd0: half_sel = half_cycles(RATE0_MBPS); // RL2
      2'd1: half_sel = half_cycles(RATE1_MBPS);
      2'd2: half_sel = half_cycles(RATE2_MBPS);
      2'd3: half_sel = half_cycles(RATE3_MBPS);
    endcase
  end

  assign tick = tx_busy_reg && half_cnt_reg == 4'h0;

  // Serializer: each bit is two half periods; rate and strobe mode are frozen per frame.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_busy_reg <= 1'b0;
      phase_reg <= 1'b1;
      ds_mode_reg <= 1'b0;
      frame_reg <= '0;
      bit_cnt_reg <= '0;
      half_cnt_reg <= '0;
      half_len_reg <= 4'h1;
      data_reg <= STOP_LEVEL;
      strobe_reg <= 1'b0;
    end
    else if (tx_start_reg)
    begin
      tx_busy_reg <= 1'b1;
      phase_reg <= 1'b1;
      half_cnt_reg <= '0;
      half_len_reg <= half_sel; // RL2
      ds_mode_reg <= ctrl_reg[CTRL_STROBE_BIT];
      frame_reg <= {START_LEVEL, tx_word_reg, ^tx_word_reg, STOP_LEVEL, STOP_LEVEL}; // RL1 RL20
      bit_cnt_reg <= 6'(FRAME_BITS);
    end
    else if (tick)
    begin
      half_cnt_reg <= half_len_reg - 4'h1;
      phase_reg <= ~phase_reg;
      if (!phase_reg && !ds_mode_reg)
      begin
        strobe_reg <= 1'b1; // RL3
      end
      else if (phase_reg && bit_cnt_reg == 6'd0)
      begin
        tx_busy_reg <= 1'b0;
        data_reg <= STOP_LEVEL; // RL20
        if (!ds_mode_reg)
        begin
          strobe_reg <= 1'b0;
        end
      end
      else if (phase_reg)
      begin
        data_reg <= frame_reg[FRAME_BITS-1]; // RL1
        frame_reg <= {frame_reg[FRAME_BITS-2:0], 1'b0};
        bit_cnt_reg <= bit_cnt_reg - 6'd1;
        if (!ds_mode_reg)
        begin
          strobe_reg <= 1'b0; // RL3
        end
        else if (frame_reg[FRAME_BITS-1] == data_reg)
        begin
          strobe_reg <= ~strobe_reg; // RL4
        end
      end
    end
    else if (tx_busy_reg)
    begin
      half_cnt_reg <= half_cnt_reg - 4'h1;
    end
  end

endmodule : tdc_serial_readout_errmon
`default_nettype wire
